// ### src/flash_wipe_seq.sv
module flash_wipe_seq #(
  parameter int SECTOR_CYCLES = wipe_pkg::SECTOR_WIPE_CYCLES,
  parameter int BLOCK_CYCLES  = wipe_pkg::BLOCK_WIPE_CYCLES,
  parameter int ARRAY_CYCLES  = wipe_pkg::ARRAY_WIPE_CYCLES
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial link from the host
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output wire logic        so_out,
  output wire logic        so_oe,
  // Protection and mode inputs, same clock as clk
  input  wire logic [4:0]  protect_level_bits,
  input  wire logic        protect_complement,
  input  wire logic        deep_power_down,
  input  wire logic        ext_busy,
  // Status
  output wire logic        op_in_progress,
  output wire logic        write_latch,
  output wire logic        busy_out_en,
  // Erase request toward the array
  output wire logic [3:0]  wipe_kind,
  output wire logic [23:0] wipe_base
);

  logic [31:0] shreg_r;
  logic [5:0]  bit_cnt_r;
  logic        in_frame_r;

  // Frame marker, cleared as soon as select is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
    end
  end

  // Shift input bits in on the rising serial clock, MSB first
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      shreg_r <= 32'h00000000;
    end else if (!cs_n) begin
      shreg_r <= {shreg_r[30:0], si};
    end
  end

  // Bit counter restarts on the first edge of each frame
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 6'h00;
    end else if (!cs_n) begin
      if (!in_frame_r) begin
        bit_cnt_r <= 6'h01;
      end else if (bit_cnt_r != wipe_pkg::CNT_SAT) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  logic cs_n_s;
  logic cs_prev_r;

  pin_sync #(
    .RESET_VAL (1'b1)
  ) u_cs_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (cs_n),
    .level (cs_n_s)
  );

  // Select edge in the system domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= cs_n_s;
    end
  end

  // Frame words are read only after the select rise: with select high there
  // are no link edges, so they stand still. The host must not start the next
  // frame within a few system cycles of that rise.
  logic        cs_rise;
  logic [5:0]  frame_cnt;
  logic [7:0]  opc8;
  logic [7:0]  opc32;
  logic [23:0] frame_addr;

  assign cs_rise    = cs_n_s & ~cs_prev_r;
  assign frame_cnt  = bit_cnt_r;
  assign opc8       = shreg_r[7:0];
  assign opc32      = shreg_r[31:24];
  assign frame_addr = shreg_r[23:0];

  // Protection of one 64 KB block, counted from the top of the array
  function automatic logic blk_protected(input logic [3:0] blk,
                                         input logic [2:0] lvl,
                                         input logic       cmp);
    logic hit;
    hit = 1'b0;
    unique case (lvl)
      3'h0:    hit = 1'b0;
      3'h1:    hit = (blk >= 4'hf);
      3'h2:    hit = (blk >= 4'he);
      3'h3:    hit = (blk >= 4'hc);
      3'h4:    hit = (blk >= 4'h8);
      default: hit = 1'b1;
    endcase
    return hit ^ cmp;
  endfunction : blk_protected

  wipe_pkg::wipe_state_e state_r;
  logic        busy;
  logic        is8;
  logic        is32;
  logic        write_latch_set_cmd;
  logic        cmd_sector;
  logic        cmd_blk32;
  logic        cmd_blk64;
  logic        cmd_array;
  logic        cmd_busy_on;
  logic        cmd_busy_off;
  logic        wipe_allowed;
  logic        addr_prot;
  logic        array_prot_ok;
  logic        go_sector;
  logic        go_blk32;
  logic        go_blk64;
  logic        go_array;
  logic        start;
  logic        timer_done;
  logic        write_latch_r;

  assign busy = (state_r == wipe_pkg::ST_WIPE);

  // Frame length decides which opcodes are even considered
  assign is8          = cs_rise && (frame_cnt == wipe_pkg::OPC_BITS);
  assign is32         = cs_rise && (frame_cnt == wipe_pkg::ADDR_BITS);
  assign write_latch_set_cmd = is8 && (opc8 == wipe_pkg::OPC_LATCH_SET);
  assign cmd_array    = is8 && ((opc8 == wipe_pkg::OPC_ARRAY_A) ||
                                (opc8 == wipe_pkg::OPC_ARRAY_B));
  assign cmd_busy_on  = is8 && (opc8 == wipe_pkg::OPC_BUSY_ON);
  assign cmd_busy_off = is8 && (opc8 == wipe_pkg::OPC_BUSY_OFF);
  assign cmd_sector   = is32 && (opc32 == wipe_pkg::OPC_SECTOR);
  assign cmd_blk32    = is32 && (opc32 == wipe_pkg::OPC_BLK32);
  assign cmd_blk64    = is32 && (opc32 == wipe_pkg::OPC_BLK64);

  // Gate shared by every erase
  assign wipe_allowed = write_latch_r && !busy && !deep_power_down;

  // Sector and block erases check the block that holds the address
  assign addr_prot = blk_protected(frame_addr[wipe_pkg::BLK_MSB:wipe_pkg::BLK_LSB],
                                   protect_level_bits[2:0], protect_complement);
  // Array erase needs the all-clear or all-set pattern
  assign array_prot_ok =
      ((protect_level_bits[2:0] == wipe_pkg::PROT_NONE) && !protect_complement) ||
      ((protect_level_bits[2:0] == wipe_pkg::PROT_ALL) && protect_complement);

  assign go_sector = cmd_sector && wipe_allowed && !addr_prot;
  assign go_blk32  = cmd_blk32 && wipe_allowed && !addr_prot;
  assign go_blk64  = cmd_blk64 && wipe_allowed && !addr_prot;
  assign go_array  = cmd_array && wipe_allowed && array_prot_ok;
  assign start     = go_sector | go_blk32 | go_blk64 | go_array;

  // Duration for the kind being started
  logic [wipe_pkg::TIMER_W-1:0] load_cycles;
  always_comb begin
    load_cycles = wipe_pkg::TIMER_W'(SECTOR_CYCLES);
    if (go_blk32 || go_blk64) begin
      load_cycles = wipe_pkg::TIMER_W'(BLOCK_CYCLES);
    end else if (go_array) begin
      load_cycles = wipe_pkg::TIMER_W'(ARRAY_CYCLES);
    end
  end

  wipe_timer #(
    .W (wipe_pkg::TIMER_W)
  ) u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .start   (start),
    .load    (load_cycles),
    .running (),
    .done    (timer_done)
  );

  // Sequencer: idle until an accepted erase, then wait for the timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= wipe_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        wipe_pkg::ST_IDLE: begin
          if (start) begin
            state_r <= wipe_pkg::ST_WIPE;
          end
        end
        wipe_pkg::ST_WIPE: begin
          if (timer_done) begin
            state_r <= wipe_pkg::ST_IDLE;
          end
        end
        default: state_r <= wipe_pkg::ST_IDLE;
      endcase
    end
  end

  logic op_in_progress_r;

  // In-progress flag follows the self-timed cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_in_progress_r <= 1'b0;
    end else if (start) begin
      op_in_progress_r <= 1'b1;
    end else if (timer_done) begin
      op_in_progress_r <= 1'b0;
    end
  end

  // Write latch: set by its command, dropped as an erase starts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_latch_r <= 1'b0;
    end else if (start) begin
      write_latch_r <= 1'b0;
    end else if (write_latch_set_cmd && !busy && !deep_power_down) begin
      write_latch_r <= 1'b1;
    end
  end

  logic [3:0]  wipe_kind_r;
  logic [23:0] wipe_base_r;

  // Target region, aligned to the erase size
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wipe_kind_r <= wipe_pkg::KIND_NONE;
      wipe_base_r <= wipe_pkg::BASE_RST;
    end else if (go_sector) begin
      wipe_kind_r <= wipe_pkg::KIND_SECTOR;
      wipe_base_r <= frame_addr & wipe_pkg::SECTOR_MASK;
    end else if (go_blk32) begin
      wipe_kind_r <= wipe_pkg::KIND_BLK32;
      wipe_base_r <= frame_addr & wipe_pkg::BLK32_MASK;
    end else if (go_blk64) begin
      wipe_kind_r <= wipe_pkg::KIND_BLK64;
      wipe_base_r <= frame_addr & wipe_pkg::BLK64_MASK;
    end else if (go_array) begin
      wipe_kind_r <= wipe_pkg::KIND_ARRAY;
      wipe_base_r <= wipe_pkg::BASE_RST;
    end
  end

  logic busy_out_en_r;

  // Ready/busy routing on the output pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_out_en_r <= 1'b0;
    end else if (!deep_power_down) begin
      if (cmd_busy_on) begin
        busy_out_en_r <= 1'b1;
      end else if (cmd_busy_off) begin
        busy_out_en_r <= 1'b0;
      end
    end
  end

  logic so_out_r;
  logic so_oe_r;

  // Pin driven only while deselected, so data reads are not disturbed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      so_oe_r  <= 1'b0;
      so_out_r <= 1'b1;
    end else begin
      so_oe_r  <= busy_out_en_r && cs_n_s;
      so_out_r <= !(op_in_progress_r || ext_busy);
    end
  end

  assign so_out         = so_out_r;
  assign so_oe          = so_oe_r;
  assign op_in_progress = op_in_progress_r;
  assign write_latch    = write_latch_r;
  assign busy_out_en    = busy_out_en_r;
  assign wipe_kind      = wipe_kind_r;
  assign wipe_base      = wipe_base_r;

  // Checks, all in the system domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_sector_start;
    go_sector |=> op_in_progress_r && (wipe_kind_r == wipe_pkg::KIND_SECTOR)
                  && (wipe_base_r[11:0] == 12'h000);
  endproperty
  a_sector_start: assert property (p_sector_start) else $error("sector start");

  property p_frame_len;
    (cs_rise && !busy && (frame_cnt != wipe_pkg::ADDR_BITS)
     && (frame_cnt != wipe_pkg::OPC_BITS)) |=> !$rose(op_in_progress_r);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("odd frame started erase");

  property p_done_clears;
    timer_done |=> !op_in_progress_r ##1 !op_in_progress_r;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("busy after done");

  property p_latch_gone;
    $fell(op_in_progress_r) |-> !write_latch_r;
  endproperty
  a_latch_gone: assert property (p_latch_gone) else $error("latch after erase");

  property p_protected;
    (cs_rise && is32 && addr_prot) |=> !$rose(op_in_progress_r);
  endproperty
  a_protected: assert property (p_protected) else $error("protected erase");

  property p_array_prot;
    (cmd_array && !array_prot_ok) |=> !$rose(op_in_progress_r);
  endproperty
  a_array_prot: assert property (p_array_prot) else $error("array prot");

  property p_so_busy;
    (busy_out_en_r && cs_n_s && op_in_progress_r) |=> so_oe_r && !so_out_r;
  endproperty
  a_so_busy: assert property (p_so_busy) else $error("busy not shown");

  property p_so_ready;
    (busy_out_en_r && cs_n_s && !op_in_progress_r && !ext_busy) |=> so_oe_r && so_out_r;
  endproperty
  a_so_ready: assert property (p_so_ready) else $error("ready not shown");

  property p_busy_off;
    (cmd_busy_off && !deep_power_down) |=> ##1 !so_oe_r;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("output still on");

  property p_busy_cmd_len;
    (cs_rise && (frame_cnt != wipe_pkg::OPC_BITS)) |=> $stable(busy_out_en_r);
  endproperty
  a_busy_cmd_len: assert property (p_busy_cmd_len) else $error("enable changed");

  property p_gate;
    (cs_rise && (!write_latch_r || deep_power_down || busy)) |=>
      $stable(wipe_kind_r) && $stable(wipe_base_r);
  endproperty
  a_gate: assert property (p_gate) else $error("erase not gated");

  c_sector: cover property (go_sector ##[1:20] op_in_progress_r);
  c_array:  cover property (go_array);
  c_blk64:  cover property (go_blk64);
  c_so_on:  cover property (cmd_busy_on ##2 so_oe_r);

endmodule : flash_wipe_seq

// ### src/wipe_pkg.sv
package wipe_pkg;

  // Command bytes seen on the serial input
  localparam logic [7:0] OPC_LATCH_SET = 8'h06;
  localparam logic [7:0] OPC_SECTOR    = 8'h20;
  localparam logic [7:0] OPC_BLK32     = 8'h52;
  localparam logic [7:0] OPC_BLK64     = 8'hd8;
  localparam logic [7:0] OPC_ARRAY_A   = 8'h60;
  localparam logic [7:0] OPC_ARRAY_B   = 8'hc7;
  localparam logic [7:0] OPC_BUSY_ON   = 8'h70;
  localparam logic [7:0] OPC_BUSY_OFF  = 8'h80;

  // Frame lengths in bits, and the saturation point of the bit counter
  localparam logic [5:0] OPC_BITS      = 6'h08;
  localparam logic [5:0] ADDR_BITS     = 6'h20;
  localparam logic [5:0] CNT_SAT       = 6'h28;

  // Address layout: 24-bit address, 64 KB blocks in bits 19:16
  localparam int         ADDR_W        = 24;
  localparam int         BLK_LSB       = 16;
  localparam int         BLK_MSB       = 19;
  localparam logic [23:0] SECTOR_MASK  = 24'hfff000;
  localparam logic [23:0] BLK32_MASK   = 24'hff8000;
  localparam logic [23:0] BLK64_MASK   = 24'hff0000;
  localparam logic [23:0] BASE_RST     = 24'h000000;

  // Protect levels: all-clear and all-set patterns of bits 2:0
  localparam logic [2:0] PROT_NONE     = 3'h0;
  localparam logic [2:0] PROT_ALL      = 3'h7;

  // Erase kind, one bit per kind
  localparam logic [3:0] KIND_NONE     = 4'h0;
  localparam logic [3:0] KIND_SECTOR   = 4'h1;
  localparam logic [3:0] KIND_BLK32    = 4'h2;
  localparam logic [3:0] KIND_BLK64    = 4'h4;
  localparam logic [3:0] KIND_ARRAY    = 4'h8;

  // Self-timed durations in microseconds, and system clock rate
  localparam int CLK_MHZ               = 125;
  localparam int SECTOR_WIPE_TIME_US   = 100;
  localparam int BLOCK_WIPE_TIME_US    = 100;
  localparam int ARRAY_WIPE_TIME_US    = 1000;
  localparam int SECTOR_WIPE_CYCLES    = SECTOR_WIPE_TIME_US * CLK_MHZ;
  localparam int BLOCK_WIPE_CYCLES     = BLOCK_WIPE_TIME_US * CLK_MHZ;
  localparam int ARRAY_WIPE_CYCLES     = ARRAY_WIPE_TIME_US * CLK_MHZ;
  localparam int TIMER_W               = 32;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WIPE = 2'b10
  } wipe_state_e;

endpackage : wipe_pkg

// ### src/pin_sync.sv
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // System side
  input  wire logic clk,
  input  wire logic rstn,
  // Pin and filtered level
  input  wire logic pin,
  output wire logic level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // Three stages; only the second reads the first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_r <= RESET_VAL;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  assign level = level_r;

endmodule : pin_sync

// ### src/wipe_timer.sv
module wipe_timer #(
  parameter int W = 32
) (
  // System side
  input  wire logic         clk,
  input  wire logic         rstn,
  // Start with a cycle count
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  // Progress
  output wire logic         running,
  output wire logic         done
);

  logic [W-1:0] cnt_r;
  logic         running_r;
  logic         done_r;

  // Count down; a load of zero behaves as one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r     <= '0;
      running_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r     <= load;
        running_r <= 1'b1;
      end else if (running_r) begin
        if (cnt_r <= W'(1)) begin
          running_r <= 1'b0;
          done_r    <= 1'b1;
        end else begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end

  assign running = running_r;
  assign done    = done_r;

endmodule : wipe_timer

// ### verification/flash_host_model.sv
module flash_host_model (
  // Serial link toward the device
  output logic sclk,
  output logic cs_n,
  output logic si
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half of the 125 ns link period
  localparam realtime HALF = 62.5;

  // Link stands still and deselected between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Shift n bits MSB first; select held low for the whole frame
  task automatic send(input logic [39:0] word, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = word[i];
      #(HALF);
      sclk = 1'b1;
      #(HALF);
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    #(HALF);
    // Deselected line shows no stale bit
    si = ~si;
    #(HALF);
  endtask : send
endmodule : flash_host_model

// ### verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Short self-timed counts, distinct for sector, block and array erases
  localparam int SEC_N = 2000;
  localparam int BLK_N = 2500;
  localparam int ARR_N = 3000;

  logic        clk, rstn, sclk, cs_n, si, so_out, so_oe;
  logic        deep_power_down, ext_busy, protect_complement;
  logic        op_in_progress, write_latch, busy_out_en;
  logic [4:0]  protect_level_bits;
  logic [3:0]  wipe_kind, kind_x;
  logic [23:0] wipe_base, base_x;
  int          miscompares, comparisons, run_cnt, last_len;

  flash_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si));

  flash_wipe_seq #(.SECTOR_CYCLES(SEC_N), .BLOCK_CYCLES(BLK_N), .ARRAY_CYCLES(ARR_N)) dut (
    .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe(so_oe), .protect_level_bits(protect_level_bits),
    .protect_complement(protect_complement), .deep_power_down(deep_power_down),
    .ext_busy(ext_busy), .op_in_progress(op_in_progress), .write_latch(write_latch),
    .busy_out_en(busy_out_en), .wipe_kind(wipe_kind), .wipe_base(wipe_base));

  // System clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Length of each busy stretch, latched when it ends
  always @(posedge clk) begin
    if (op_in_progress === 1'b1) begin
      run_cnt++;
    end else if (run_cnt != 0) begin
      last_len = run_cnt;
      run_cnt  = 0;
    end
  end

  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One frame, then room for the select rise to cross domains
  task automatic frame(input logic [39:0] w, input int n);
    host.send(w, n);
    repeat (10) @(posedge clk);
    #1;
  endtask : frame

  task automatic set_latch;
    frame(40'h06, 8);
  endtask : set_latch

  task automatic chk_start(input logic [3:0] k, input logic [23:0] b);
    kind_x = k;
    base_x = b;
    check(wipe_kind, k);
    check(wipe_base, b);
    check(op_in_progress, 1'b1);
  endtask : chk_start

  // Bounded wait for the cycle to end, then its length
  task automatic finish_run(input int len);
    for (int i = 0; i < 4000 && op_in_progress !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    check(op_in_progress, 1'b0);
    check(last_len, len);
    check(write_latch, 1'b0);
  endtask : finish_run

  task automatic refused;
    check(op_in_progress, 1'b0);
    check(wipe_kind, kind_x);
    check(wipe_base, base_x);
  endtask : refused

  task automatic t_sector;
    frame(40'h20012345, 32);
    refused();
    check(write_latch, 1'b0);
    set_latch();
    frame(40'h20012345, 32);
    chk_start(4'h1, 24'h012000);
    check(so_oe, 1'b0);
    // New requests during the cycle change nothing
    set_latch();
    frame(40'hd8050000, 32);
    check(wipe_kind, 4'h1);
    check(wipe_base, 24'h012000);
    finish_run(SEC_N + 1);
  endtask : t_sector

  task automatic t_blocks;
    logic [39:0] w [2] = '{40'h5203abcd, 40'hd805abcd};
    logic [3:0]  k [2] = '{4'h2, 4'h4};
    logic [23:0] b [2] = '{24'h038000, 24'h050000};
    for (int i = 0; i < 2; i++) begin
      set_latch();
      frame(w[i], 32);
      chk_start(k[i], b[i]);
      finish_run(BLK_N + 1);
    end
  endtask : t_blocks

  // Frames one bit long or short are discarded
  task automatic t_length;
    set_latch();
    frame({8'h20, 24'h012345, 1'b0}, 33);
    refused();
    frame(40'h20012345 >> 1, 31);
    refused();
    frame({8'h60, 1'b0}, 9);
    refused();
    check(write_latch, 1'b1);
  endtask : t_length

  task automatic t_array;
    logic [7:0] op [4] = '{8'h60, 8'hc7, 8'h60, 8'hc7};
    logic [4:0] lv [4] = '{5'h00, 5'h07, 5'h01, 5'h07};
    logic       cp [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      protect_level_bits = lv[i];
      protect_complement = cp[i];
      set_latch();
      frame({32'h0, op[i]}, 8);
      if (i < 2) begin
        chk_start(4'h8, 24'h000000);
        finish_run(ARR_N + 1);
      end else begin
        refused();
      end
    end
    protect_level_bits = 5'h00;
    protect_complement = 1'b0;
  endtask : t_array

  // Level one guards the top 64 KB block only
  task automatic t_protect;
    protect_level_bits = 5'h01;
    set_latch();
    frame(40'h200f1000, 32);
    refused();
    frame(40'hd80fffff, 32);
    refused();
    frame(40'h520ebcde, 32);
    chk_start(4'h2, 24'h0e8000);
    finish_run(BLK_N + 1);
    protect_level_bits = 5'h00;
  endtask : t_protect

  task automatic t_busy_pin;
    frame({8'h70, 1'b1}, 9);
    check(busy_out_en, 1'b0);
    frame(40'h70, 8);
    check(busy_out_en, 1'b1);
    check(so_oe, 1'b1);
    check(so_out, 1'b1);
    ext_busy = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(so_out, 1'b0);
    ext_busy = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(so_out, 1'b1);
    set_latch();
    frame(40'h20000000, 32);
    chk_start(4'h1, 24'h000000);
    check(so_out, 1'b0);
    finish_run(SEC_N + 1);
    repeat (2) @(posedge clk);
    #1;
    check(so_out, 1'b1);
    frame(40'h80, 8);
    check(busy_out_en, 1'b0);
    check(so_oe, 1'b0);
  endtask : t_busy_pin

  task automatic t_power_down;
    // Latch set first, so only power-down can block the erase
    set_latch();
    deep_power_down = 1'b1;
    frame(40'h20012345, 32);
    refused();
    check(write_latch, 1'b1);
    deep_power_down = 1'b0;
  endtask : t_power_down

  // Watchdog, far beyond the expected run time
  initial begin
    #500000;
    miscompares++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    deep_power_down = 1'b0;
    ext_busy = 1'b0;
    protect_level_bits = 5'h00;
    protect_complement = 1'b0;
    kind_x = 4'h0;
    base_x = 24'h000000;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(op_in_progress, 1'b0);
    check(wipe_kind, 4'h0);
    check(so_oe, 1'b0);
    t_sector();
    t_blocks();
    t_length();
    t_array();
    t_protect();
    t_busy_pin();
    t_power_down();
    finish_test();
  end
endmodule : tb
